// ===== hdl/pwm_fade_pkg.sv
// shared constants, register map and field layouts of the pwm fade controller
package pwm_fade_pkg;
    localparam int NUM_CH = 16;
    localparam int CH_PER_GRP = 8;
    localparam int NUM_TMR = 8;
    localparam int TMR_PER_GRP = 4;
    localparam int CNT_W = 20;
    localparam int DIV_INT_W = 10;
    localparam int DIV_FRAC_W = 8;
    localparam int RES_W = 5;
    localparam int DUTY_W = 25;
    localparam int DUTY_FRAC_W = 4;
    localparam int FADE_W = 10;
    localparam int TSEL_W = 2;
    localparam int CH_IDX_W = 4;
    localparam int TMR_IDX_W = 3;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;

    // register map, byte addresses
    localparam logic [ADDR_W-1:0] CH_BASE = 12'h000;
    localparam logic [ADDR_W-1:0] CH_STRIDE = 12'h010;
    localparam logic [1:0] CH_CONF0_SEL = 2'h0;
    localparam logic [1:0] CH_HPOINT_SEL = 2'h1;
    localparam logic [1:0] CH_DUTY_SEL = 2'h2;
    localparam logic [1:0] CH_CONF1_SEL = 2'h3;
    localparam logic [ADDR_W-1:0] DUTY_R_BASE = 12'h100;
    localparam logic [ADDR_W-1:0] TMR_CONF_BASE = 12'h180;
    localparam logic [ADDR_W-1:0] TMR_CNT_BASE = 12'h1A0;
    localparam logic [ADDR_W-1:0] GLOBAL_CONF_ADDR = 12'h1C0;
    localparam logic [ADDR_W-1:0] FADE_BUSY_ADDR = 12'h1C4;
    localparam logic [ADDR_W-1:0] PWM_LEVEL_ADDR = 12'h1C8;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // channel configuration register 0
    typedef struct packed {
        logic [TSEL_W-1:0] timer_sel;
        logic out_en;
    } ch_conf0_t;

    // channel configuration register 1; fade_start is a self-clearing pulse
    typedef struct packed {
        logic fade_start;
        logic fade_inc;
        logic [FADE_W-1:0] fade_num;
        logic [FADE_W-1:0] fade_cycle;
        logic [FADE_W-1:0] fade_scale;
    } ch_conf1_t;

    typedef struct packed {
        ch_conf0_t conf0;
        logic [CNT_W-1:0] channel_high_point;
        ch_conf1_t conf1;
    } ch_cfg_t;

    // timer configuration register; low_speed_param_update self-clears
    typedef struct packed {
        logic low_speed_param_update;
        logic timer_clock_select;
        logic counter_reset;
        logic counter_pause;
        logic [RES_W-1:0] counter_resolution_bits;
        logic [DIV_INT_W+DIV_FRAC_W-1:0] timer_divider_value;
    } tmr_cfg_t;

    localparam ch_cfg_t CH_CFG_RESET = '0;
    // timers come out of reset paused
    localparam tmr_cfg_t TMR_CFG_RESET = '{counter_pause: 1'b1, default: '0};
endpackage

// ===== hdl/pwm_timer.sv
// one pwm timer: fractional divider and counter of programmable width
`timescale 1ns/1ps
module pwm_timer #(
    parameter bit GLITCH_FREE = 1'b1
)
(
    input wire logic ref_clk_in,
    input wire logic reset_n_in,
    input wire logic src_tick_in,
    input wire logic param_update_in,
    input wire pwm_fade_pkg::tmr_cfg_t cfg_in,
    output logic [pwm_fade_pkg::CNT_W-1:0] count_out,
    output logic overflow_out
);
    import pwm_fade_pkg::*;

    logic [DIV_INT_W+DIV_FRAC_W-1:0] act_div_ff;
    logic [RES_W-1:0] act_res_ff;
    logic [DIV_INT_W:0] div_cnt_ff;
    logic [DIV_FRAC_W-1:0] frac_acc_ff;
    logic [CNT_W-1:0] cnt_ff;
    logic ovf_ff;

    wire [DIV_INT_W-1:0] div_int = act_div_ff[DIV_INT_W+DIV_FRAC_W-1:DIV_FRAC_W];
    wire [DIV_FRAC_W-1:0] div_frac = act_div_ff[DIV_FRAC_W-1:0];
    wire [DIV_FRAC_W:0] frac_sum = {1'b0, frac_acc_ff} + {1'b0, div_frac};
    wire long_period = frac_sum[DIV_FRAC_W];
    wire [DIV_INT_W:0] period_raw = {1'b0, div_int} + {{DIV_INT_W{1'b0}}, long_period};
    wire [DIV_INT_W:0] period = (period_raw == '0) ? (DIV_INT_W+1)'(1) : period_raw;
    wire running = !cfg_in.counter_pause && !cfg_in.counter_reset;
    wire div_tick = src_tick_in && running && ((div_cnt_ff + 1'b1) >= period);
    wire [CNT_W:0] top_wide = ((CNT_W+1)'(1) << act_res_ff) - 1'b1;
    wire [CNT_W-1:0] top = (act_res_ff >= RES_W'(CNT_W)) ? '1 : top_wide[CNT_W-1:0];
    wire wrap = (cnt_ff == top);
    // high-speed loads after overflow; low-speed on update bit
    wire load_cfg = GLITCH_FREE ? (cfg_in.counter_reset || (div_tick && wrap))
                                : param_update_in;

    always_ff @(posedge ref_clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            act_div_ff <= '0;
            act_res_ff <= '0;
        end
        else if (load_cfg)
        begin
            act_div_ff <= cfg_in.timer_divider_value;
            act_res_ff <= cfg_in.counter_resolution_bits;
        end
    end

    // count divider clocks, wrap at top
    always_ff @(posedge ref_clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            div_cnt_ff <= '0;
            frac_acc_ff <= '0;
            cnt_ff <= '0;
            ovf_ff <= 1'b0;
        end
        else if (cfg_in.counter_reset)
        begin
            div_cnt_ff <= '0;
            frac_acc_ff <= '0;
            cnt_ff <= '0;
            ovf_ff <= 1'b0;
        end
        else
        begin
            ovf_ff <= div_tick && wrap;
            if (div_tick)
            begin
                div_cnt_ff <= '0;
                frac_acc_ff <= frac_sum[DIV_FRAC_W-1:0];
                cnt_ff <= wrap ? '0 : cnt_ff + 1'b1;
            end
            else if (src_tick_in && running)
            begin
                div_cnt_ff <= div_cnt_ff + 1'b1;
            end
        end
    end

    assign count_out = cnt_ff;
    assign overflow_out = ovf_ff;
endmodule

// ===== hdl/pwm_channel.sv
// one pwm channel: compare, dither and duty fade
`timescale 1ns/1ps
module pwm_channel
(
    input wire logic ref_clk_in,
    input wire logic reset_n_in,
    input wire logic [pwm_fade_pkg::CNT_W-1:0] count_in,
    input wire logic cycle_in,
    input wire pwm_fade_pkg::ch_cfg_t cfg_in,
    input wire logic duty_wr_in,
    input wire logic [pwm_fade_pkg::DUTY_W-1:0] duty_wdata_in,
    input wire logic fade_start_in,
    output logic pwm_out,
    output logic [pwm_fade_pkg::DUTY_W-1:0] duty_out,
    output logic fade_busy_out,
    output logic fade_done_out
);
    import pwm_fade_pkg::*;

    logic [DUTY_W-1:0] duty_ff;
    logic [DUTY_FRAC_W-1:0] dith_acc_ff;
    logic extra_ff;
    logic pwm_ff;
    logic fading_ff;
    logic [FADE_W-1:0] cyc_cnt_ff;
    logic [FADE_W-1:0] step_cnt_ff;
    logic done_ff;

    localparam int INT_W = DUTY_W - DUTY_FRAC_W;
    wire [INT_W-1:0] duty_int = duty_ff[DUTY_W-1:DUTY_FRAC_W];
    wire [DUTY_FRAC_W:0] dith_sum = {1'b0, dith_acc_ff} + {1'b0, duty_ff[DUTY_FRAC_W-1:0]};
    // low point is high point plus integer duty (plus dither)
    wire [INT_W-1:0] low_sum = INT_W'(cfg_in.channel_high_point) + duty_int
                               + {{(INT_W-1){1'b0}}, extra_ff};
    wire [CNT_W-1:0] low_point = low_sum[CNT_W-1:0];
    wire hit_high = (count_in == cfg_in.channel_high_point);
    wire hit_low = (count_in == low_point);
    wire [FADE_W-1:0] cyc_len = (cfg_in.conf1.fade_cycle == '0) ? FADE_W'(1)
                                                                 : cfg_in.conf1.fade_cycle;
    wire fade_tick = fading_ff && cycle_in && ((cyc_cnt_ff + 1'b1) >= cyc_len);
    wire last_step = ((step_cnt_ff + 1'b1) >= cfg_in.conf1.fade_num);
    wire [INT_W-1:0] scale_ext = INT_W'(cfg_in.conf1.fade_scale);
    wire [INT_W-1:0] faded = cfg_in.conf1.fade_inc ? duty_int + scale_ext
                                                   : duty_int - scale_ext;

    // latch high at high point, low at low point
    always_ff @(posedge ref_clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
            pwm_ff <= 1'b0;
        else if (!cfg_in.conf0.out_en || hit_low)
            pwm_ff <= 1'b0;
        else if (hit_high)
            pwm_ff <= 1'b1;
    end

    // fraction carry lengthens one period in sixteen per unit
    always_ff @(posedge ref_clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            dith_acc_ff <= '0;
            extra_ff <= 1'b0;
        end
        else if (cycle_in)
        begin
            dith_acc_ff <= dith_sum[DUTY_FRAC_W-1:0];
            extra_ff <= dith_sum[DUTY_FRAC_W];
        end
    end

    always_ff @(posedge ref_clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            duty_ff <= '0;
            fading_ff <= 1'b0;
            cyc_cnt_ff <= '0;
            step_cnt_ff <= '0;
            done_ff <= 1'b0;
        end
        else
        begin
            done_ff <= fade_tick && last_step;
            if (duty_wr_in)
                duty_ff <= duty_wdata_in;
            else if (fade_tick)
                duty_ff <= {faded, duty_ff[DUTY_FRAC_W-1:0]};
            if (fade_start_in)
            begin
                fading_ff <= 1'b1;
                cyc_cnt_ff <= '0;
                step_cnt_ff <= '0;
            end
            else if (fade_tick)
            begin
                cyc_cnt_ff <= '0;
                step_cnt_ff <= step_cnt_ff + 1'b1;
                fading_ff <= !last_step;
            end
            else if (fading_ff && cycle_in)
                cyc_cnt_ff <= cyc_cnt_ff + 1'b1;
        end
    end

    assign pwm_out = pwm_ff;
    assign duty_out = duty_ff;
    assign fade_busy_out = fading_ff;
    assign fade_done_out = done_ff;
endmodule

// ===== hdl/pwm_fade_controller.sv
// top of the pwm fade controller: axi4-lite registers, timers and channels
// How it works
// - sixteen channels, eight fast, eight slow
// - each group has four selectable timers
// - fast timer clock: bus clock or reference tick
// - divider is ten integer, eight fraction bits
// - B long periods spread over 256
// - counter wraps at top, flags overflow
// - software resets, pauses and reads counters
// - twenty-bit count drives attached channels
// - slow timers use tick or selectable slow clock
// - fast timer settings apply after overflow
// - slow timer settings apply on update bit
// - output set high at high point
// - output set low at high plus duty
// - fractional duty dithers pulse length
// - start bit begins fade, direction bit
// - each fade period adds or subtracts step
// - fade ends after count, raises done
// - separate fade and overflow events per unit
`timescale 1ns/1ps
module pwm_fade_controller
(
    input wire logic ref_clk_in,
    input wire logic reset_n_in,
    input wire logic ref_tick_in,
    input wire logic rtc8m_tick_in,
    input wire logic [pwm_fade_pkg::ADDR_W-1:0] s_axi_awaddr_in,
    input wire logic s_axi_awvalid_in,
    output logic s_axi_awready_out,
    input wire logic [pwm_fade_pkg::DATA_W-1:0] s_axi_wdata_in,
    input wire logic [3:0] s_axi_wstrb_in,
    input wire logic s_axi_wvalid_in,
    output logic s_axi_wready_out,
    output logic [1:0] s_axi_bresp_out,
    output logic s_axi_bvalid_out,
    input wire logic s_axi_bready_in,
    input wire logic [pwm_fade_pkg::ADDR_W-1:0] s_axi_araddr_in,
    input wire logic s_axi_arvalid_in,
    output logic s_axi_arready_out,
    output logic [pwm_fade_pkg::DATA_W-1:0] s_axi_rdata_out,
    output logic [1:0] s_axi_rresp_out,
    output logic s_axi_rvalid_out,
    input wire logic s_axi_rready_in,
    output logic [pwm_fade_pkg::NUM_CH-1:0] pwm_out,
    output logic [pwm_fade_pkg::NUM_CH-1:0] fade_finished_flag_out,
    output logic [pwm_fade_pkg::NUM_TMR-1:0] timer_overflow_out
);
    import pwm_fade_pkg::*;

    ch_cfg_t ch_cfg_ff [NUM_CH];
    tmr_cfg_t tmr_cfg_ff [NUM_TMR];
    logic slow_sel_ff;
    logic [NUM_CH-1:0] fade_start_ff;
    logic [NUM_CH-1:0] duty_wr_ff;
    logic [DUTY_W-1:0] duty_wdata_ff;
    logic [NUM_TMR-1:0] para_up_ff;
    logic bvalid_ff;
    logic [1:0] bresp_ff;
    logic rvalid_ff;
    logic [1:0] rresp_ff;
    logic [DATA_W-1:0] rdata_ff;

    logic [CNT_W-1:0] tmr_count [NUM_TMR];
    logic [NUM_TMR-1:0] tmr_ovf;
    logic [DUTY_W-1:0] ch_duty [NUM_CH];
    logic [NUM_CH-1:0] ch_busy;
    logic [NUM_CH-1:0] ch_done;
    logic [NUM_CH-1:0] ch_pwm;

    // write address decode
    wire wr_go = s_axi_awvalid_in && s_axi_wvalid_in && !bvalid_ff;
    wire [ADDR_W-1:0] wa = s_axi_awaddr_in;
    wire [CH_IDX_W-1:0] w_ch = wa[CH_IDX_W+3:4];
    wire [1:0] w_sel = wa[3:2];
    wire [TMR_IDX_W-1:0] w_tmr = wa[TMR_IDX_W+1:2];
    wire w_is_ch = (wa >= CH_BASE) && (wa < CH_BASE + CH_STRIDE * NUM_CH);
    wire w_is_tmr = (wa >= TMR_CONF_BASE) && (wa < TMR_CNT_BASE);
    wire w_is_glb = (wa[ADDR_W-1:2] == GLOBAL_CONF_ADDR[ADDR_W-1:2]);
    wire w_hit = w_is_ch || w_is_tmr || w_is_glb;
    wire w_full = (s_axi_wstrb_in == 4'hF);

    // read address decode
    wire rd_go = s_axi_arvalid_in && !rvalid_ff;
    wire [ADDR_W-1:0] ra = s_axi_araddr_in;
    wire [CH_IDX_W-1:0] r_ch = ra[CH_IDX_W+3:4];
    wire [1:0] r_sel = ra[3:2];
    wire [CH_IDX_W-1:0] r_dch = ra[CH_IDX_W+1:2];
    wire [TMR_IDX_W-1:0] r_tmr = ra[TMR_IDX_W+1:2];
    wire r_is_ch = (ra >= CH_BASE) && (ra < CH_BASE + CH_STRIDE * NUM_CH);
    wire r_is_dr = (ra >= DUTY_R_BASE) && (ra < TMR_CONF_BASE);
    wire r_is_tmr = (ra >= TMR_CONF_BASE) && (ra < TMR_CNT_BASE);
    wire r_is_cnt = (ra >= TMR_CNT_BASE) && (ra < GLOBAL_CONF_ADDR);
    wire r_is_glb = (ra[ADDR_W-1:2] == GLOBAL_CONF_ADDR[ADDR_W-1:2]);
    wire r_is_busy = (ra[ADDR_W-1:2] == FADE_BUSY_ADDR[ADDR_W-1:2]);
    wire r_is_lvl = (ra[ADDR_W-1:2] == PWM_LEVEL_ADDR[ADDR_W-1:2]);

    ch_cfg_t r_cfg;
    assign r_cfg = ch_cfg_t'(ch_cfg_ff[r_ch]);
    wire [DATA_W-1:0] ch_word =
        (r_sel == CH_CONF0_SEL)  ? DATA_W'(r_cfg.conf0) :
        (r_sel == CH_HPOINT_SEL) ? DATA_W'(r_cfg.channel_high_point) :
        (r_sel == CH_DUTY_SEL)   ? DATA_W'(ch_duty[r_ch]) :
                                   DATA_W'(r_cfg.conf1);
    wire [DATA_W-1:0] rd_word =
        r_is_ch   ? ch_word :
        r_is_dr   ? DATA_W'(ch_duty[r_dch]) :
        r_is_tmr  ? DATA_W'(tmr_cfg_ff[r_tmr]) :
        r_is_cnt  ? DATA_W'(tmr_count[r_tmr]) :
        r_is_glb  ? DATA_W'(slow_sel_ff) :
        r_is_busy ? DATA_W'(ch_busy) :
        r_is_lvl  ? DATA_W'(ch_pwm) : '0;
    wire r_hit = r_is_ch || r_is_dr || r_is_tmr || r_is_cnt || r_is_glb
                 || r_is_busy || r_is_lvl;

    always_ff @(posedge ref_clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            for (int i = 0; i < NUM_CH; i++)
                ch_cfg_ff[i] <= CH_CFG_RESET;
            for (int i = 0; i < NUM_TMR; i++)
                tmr_cfg_ff[i] <= TMR_CFG_RESET;
            slow_sel_ff <= 1'b0;
        end
        else if (wr_go && w_full)
        begin
            if (w_is_ch && w_sel == CH_CONF0_SEL)
                ch_cfg_ff[w_ch].conf0 <= ch_conf0_t'(s_axi_wdata_in[$bits(ch_conf0_t)-1:0]);
            else if (w_is_ch && w_sel == CH_HPOINT_SEL)
                ch_cfg_ff[w_ch].channel_high_point <= s_axi_wdata_in[CNT_W-1:0];
            else if (w_is_ch && w_sel == CH_CONF1_SEL)
            begin
                ch_cfg_ff[w_ch].conf1 <= ch_conf1_t'(s_axi_wdata_in);
                ch_cfg_ff[w_ch].conf1.fade_start <= 1'b0;
            end
            else if (w_is_tmr)
            begin
                tmr_cfg_ff[w_tmr] <= tmr_cfg_t'(s_axi_wdata_in[$bits(tmr_cfg_t)-1:0]);
                tmr_cfg_ff[w_tmr].low_speed_param_update <= 1'b0;
            end
            else if (w_is_glb)
                slow_sel_ff <= s_axi_wdata_in[0];
        end
    end

    wire [DATA_W-1:0] wd = s_axi_wdata_in;
    ch_conf1_t w_conf1;
    tmr_cfg_t w_tcfg;
    assign w_conf1 = ch_conf1_t'(wd);
    assign w_tcfg = tmr_cfg_t'(wd[$bits(tmr_cfg_t)-1:0]);
    wire wr_ok = wr_go && w_full;

    always_ff @(posedge ref_clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            fade_start_ff <= '0;
            duty_wr_ff <= '0;
            duty_wdata_ff <= '0;
            para_up_ff <= '0;
        end
        else
        begin
            fade_start_ff <= '0;
            duty_wr_ff <= '0;
            para_up_ff <= '0;
            if (wr_ok && w_is_ch && w_sel == CH_CONF1_SEL && w_conf1.fade_start)
                fade_start_ff[w_ch] <= 1'b1;
            if (wr_ok && w_is_ch && w_sel == CH_DUTY_SEL)
            begin
                duty_wr_ff[w_ch] <= 1'b1;
                duty_wdata_ff <= wd[DUTY_W-1:0];
            end
            // update bit loads slow timer settings
            if (wr_ok && w_is_tmr && w_tcfg.low_speed_param_update)
                para_up_ff[w_tmr] <= 1'b1;
        end
    end

    // axi4-lite write response
    always_ff @(posedge ref_clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            bvalid_ff <= 1'b0;
            bresp_ff <= RESP_OKAY;
        end
        else if (wr_go)
        begin
            bvalid_ff <= 1'b1;
            bresp_ff <= w_hit ? RESP_OKAY : RESP_SLVERR;
        end
        else if (s_axi_bready_in)
            bvalid_ff <= 1'b0;
    end

    // axi4-lite read data
    always_ff @(posedge ref_clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            rvalid_ff <= 1'b0;
            rresp_ff <= RESP_OKAY;
            rdata_ff <= '0;
        end
        else if (rd_go)
        begin
            rvalid_ff <= 1'b1;
            rresp_ff <= r_hit ? RESP_OKAY : RESP_SLVERR;
            rdata_ff <= rd_word;
        end
        else if (s_axi_rready_in)
            rvalid_ff <= 1'b0;
    end

    assign s_axi_awready_out = wr_go;
    assign s_axi_wready_out = wr_go;
    assign s_axi_bvalid_out = bvalid_ff;
    assign s_axi_bresp_out = bresp_ff;
    assign s_axi_arready_out = rd_go;
    assign s_axi_rvalid_out = rvalid_ff;
    assign s_axi_rresp_out = rresp_ff;
    assign s_axi_rdata_out = rdata_ff;

    // slow source is the bus clock or the 8 MHz tick
    wire slow_tick = slow_sel_ff ? 1'b1 : rtc8m_tick_in;

    // four fast timers then four slow timers
    for (genvar t = 0; t < NUM_TMR; t++)
    begin : g_tmr
        localparam bit FAST = (t < TMR_PER_GRP);
        // fast timers pick bus clock or reference tick
        wire alt_tick = FAST ? 1'b1 : slow_tick;
        wire src_tick = tmr_cfg_ff[t].timer_clock_select ? alt_tick : ref_tick_in;
        pwm_timer #(.GLITCH_FREE(FAST)) u_tmr (
            .ref_clk_in(ref_clk_in),
            .reset_n_in(reset_n_in),
            .src_tick_in(src_tick),
            .param_update_in(para_up_ff[t]),
            .cfg_in(tmr_cfg_ff[t]),
            .count_out(tmr_count[t]),
            .overflow_out(tmr_ovf[t])
        );
    end

    // eight fast and eight slow channels share the channel module
    for (genvar c = 0; c < NUM_CH; c++)
    begin : g_ch
        localparam int GRP_BASE = (c / CH_PER_GRP) * TMR_PER_GRP;
        wire [TMR_IDX_W-1:0] tsel = TMR_IDX_W'(GRP_BASE) +
                                    TMR_IDX_W'(ch_cfg_ff[c].conf0.timer_sel);
        pwm_channel u_ch (
            .ref_clk_in(ref_clk_in),
            .reset_n_in(reset_n_in),
            .count_in(tmr_count[tsel]),
            .cycle_in(tmr_ovf[tsel]),
            .cfg_in(ch_cfg_ff[c]),
            .duty_wr_in(duty_wr_ff[c]),
            .duty_wdata_in(duty_wdata_ff),
            .fade_start_in(fade_start_ff[c]),
            .pwm_out(ch_pwm[c]),
            .duty_out(ch_duty[c]),
            .fade_busy_out(ch_busy[c]),
            .fade_done_out(ch_done[c])
        );
    end

    assign pwm_out = ch_pwm;
    assign fade_finished_flag_out = ch_done;
    assign timer_overflow_out = tmr_ovf;
endmodule

// ===== sim/pwm_load_model.sv
// load model: counts the cycles a watched pwm output spends high
`timescale 1ns/1ps
module pwm_load_model
(
    input wire logic ref_clk_in,
    input wire logic [15:0] pwm_in,
    input wire logic [3:0] ch_sel_in,
    input wire logic gate_in,
    output logic [15:0] high_count_out
);
    always_ff @(posedge ref_clk_in)
    begin
        if (!gate_in)
            high_count_out <= 16'h0000;
        else if (pwm_in[ch_sel_in])
            high_count_out <= high_count_out + 16'h0001;
    end
endmodule

// ===== sim/pwm_fade_monitor.sv
// bus handshake and output checks of the pwm fade controller
`timescale 1ns/1ps
module pwm_fade_monitor
(
    input wire logic ref_clk_in,
    input wire logic reset_n_in,
    input wire logic s_axi_awvalid_in,
    input wire logic s_axi_awready_out,
    input wire logic s_axi_wvalid_in,
    input wire logic s_axi_wready_out,
    input wire logic [1:0] s_axi_bresp_out,
    input wire logic s_axi_bvalid_out,
    input wire logic s_axi_bready_in,
    input wire logic s_axi_arvalid_in,
    input wire logic s_axi_arready_out,
    input wire logic [31:0] s_axi_rdata_out,
    input wire logic s_axi_rvalid_out,
    input wire logic s_axi_rready_in,
    input wire logic [15:0] pwm_out,
    input wire logic [15:0] fade_finished_flag_out
);
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!reset_n_in);
    write_take_a: assert property (s_axi_awvalid_in && s_axi_wvalid_in && !s_axi_bvalid_out
        |-> s_axi_awready_out && s_axi_wready_out ##1 s_axi_bvalid_out) else $error("write lost");
    write_idle_a: assert property (!s_axi_bvalid_out && !(s_axi_awvalid_in && s_axi_wvalid_in)
        |=> !s_axi_bvalid_out) else $error("stray write response");
    aw_pair_a: assert property (s_axi_awvalid_in && s_axi_awready_out
        |-> s_axi_wvalid_in && s_axi_wready_out) else $error("address taken alone");
    bresp_hold_a: assert property (s_axi_bvalid_out && !s_axi_bready_in
        |=> s_axi_bvalid_out && $stable(s_axi_bresp_out)) else $error("write response dropped");
    read_take_a: assert property (s_axi_arvalid_in && !s_axi_rvalid_out
        |-> s_axi_arready_out ##1 s_axi_rvalid_out) else $error("read lost");
    rdata_hold_a: assert property (s_axi_rvalid_out && !s_axi_rready_in
        |=> s_axi_rvalid_out && $stable(s_axi_rdata_out)) else $error("read data dropped");
    reset_low_a: assert property ($rose(reset_n_in) |-> pwm_out == 16'h0000)
        else $error("output high after reset");
    done_pulse_a: assert property (fade_finished_flag_out != 16'h0000
        |=> (fade_finished_flag_out & $past(fade_finished_flag_out)) == 16'h0000)
        else $error("fade done longer than one cycle");
endmodule

// ===== sim/pwm_fade_controller_tb_top.sv
// self-checking bench of the pwm fade controller
`timescale 1ns/1ps
module pwm_fade_controller_tb_top;
    import pwm_fade_pkg::*;
    logic ref_clk_in, reset_n_in, ref_tick_in, rtc8m_tick_in, gate;
    logic s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in, s_axi_arvalid_in, s_axi_rready_in;
    logic s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out;
    logic s_axi_rvalid_out;
    logic [ADDR_W-1:0] s_axi_awaddr_in, s_axi_araddr_in;
    logic [DATA_W-1:0] s_axi_wdata_in, s_axi_rdata_out, v, w;
    logic [3:0] s_axi_wstrb_in, lsel;
    logic [1:0] s_axi_bresp_out, s_axi_rresp_out, r;
    logic [15:0] pwm_out, fade_finished_flag_out, high_cnt;
    logic [7:0] timer_overflow_out;
    int bad_count = 0, num_checks = 0, tc = 0, n, c, h;
    pwm_fade_controller dut (.*);
    pwm_load_model load (.ref_clk_in(ref_clk_in), .pwm_in(pwm_out), .ch_sel_in(lsel),
        .gate_in(gate), .high_count_out(high_cnt));
    initial
    begin
        ref_clk_in = 1'b0;
        forever #10 ref_clk_in = ~ref_clk_in;
    end
    // ticks: reference every 50 cycles, slow source every 6
    always @(posedge ref_clk_in)
    begin
        tc <= tc + 1;
        ref_tick_in <= (tc % 50 == 0);
        rtc8m_tick_in <= (tc % 6 == 0);
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic close_out;
        if (bad_count == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic axi_wr(input logic [11:0] a, input logic [31:0] d);
        s_axi_awaddr_in <= a;
        s_axi_wdata_in <= d;
        {s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in} <= 3'h7;
        do @(negedge ref_clk_in); while (!(s_axi_awready_out && s_axi_wready_out));
        @(posedge ref_clk_in);
        {s_axi_awvalid_in, s_axi_wvalid_in} <= 2'h0;
        do @(negedge ref_clk_in); while (!s_axi_bvalid_out);
        r = s_axi_bresp_out;
        @(posedge ref_clk_in);
    endtask
    task automatic axi_rd(input logic [11:0] a);
        s_axi_araddr_in <= a;
        {s_axi_arvalid_in, s_axi_rready_in} <= 2'h3;
        do @(negedge ref_clk_in); while (!s_axi_arready_out);
        @(posedge ref_clk_in);
        s_axi_arvalid_in <= 1'b0;
        do @(negedge ref_clk_in); while (!s_axi_rvalid_out);
        {v, r} = {s_axi_rdata_out, s_axi_rresp_out};
        @(posedge ref_clk_in);
    endtask
    // cycles over k timer periods and high cycles of channel ch meanwhile
    task automatic span(input int t, input int k, input int ch);
        lsel = ch[3:0];
        do @(negedge ref_clk_in); while (timer_overflow_out[t] !== 1'b1);
        gate = 1'b1;
        c = 0;
        repeat (k)
        begin
            do
            begin
                @(negedge ref_clk_in);
                c++;
            end
            while (timer_overflow_out[t] !== 1'b1);
        end
        h = high_cnt;
        gate = 1'b0;
        @(posedge ref_clk_in);
    endtask
    task automatic fade_wait(input int ch);
        n = 0;
        do
        begin
            @(negedge ref_clk_in);
            n++;
        end
        while (fade_finished_flag_out[ch] !== 1'b1 && n < 400);
        chk(n < 400, 1);
        @(posedge ref_clk_in);
    endtask
    function automatic logic [31:0] tcfg(logic up, logic cs, logic rs, logic pz, logic [17:0] dv);
        return {5'h00, up, cs, rs, pz, 5'h03, dv};
    endfunction
    initial
    begin
        {reset_n_in, ref_tick_in, rtc8m_tick_in, gate, lsel} = '0;
        {s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in, s_axi_arvalid_in} = '0;
        {s_axi_rready_in, s_axi_awaddr_in, s_axi_araddr_in, s_axi_wdata_in} = '0;
        s_axi_wstrb_in = 4'hF;
        repeat (20) @(posedge ref_clk_in);
        reset_n_in <= 1'b1;
        @(posedge ref_clk_in);
        axi_rd(TMR_CNT_BASE);
        chk(v, 0);
        axi_rd(PWM_LEVEL_ADDR);
        chk(v, 0);
        axi_rd(12'hFFC);
        chk(v, 0);
        chk(r, RESP_SLVERR);
        axi_wr(12'hFFC, 32'h1);
        chk(r, RESP_SLVERR);
        axi_wr(TMR_CONF_BASE, tcfg(0, 1, 0, 0, 18'h00100));
        axi_wr(CH_BASE, 32'h1);
        axi_wr(CH_BASE + 12'h004, 32'h2);
        axi_wr(CH_BASE + 12'h008, 32'h30);
        span(0, 4, 0);
        chk(c, 32);
        chk(h, 12);
        axi_wr(CH_BASE + 12'h008, 32'h38);
        span(0, 16, 0);
        chk(h, 56);
        axi_wr(TMR_CONF_BASE, tcfg(0, 1, 0, 0, 18'h00180));
        span(0, 1, 0);
        span(0, 32, 0);
        chk(c, 384);
        axi_wr(TMR_CONF_BASE, tcfg(0, 1, 0, 1, 18'h00100));
        repeat (12) @(posedge ref_clk_in);
        axi_rd(TMR_CNT_BASE);
        w = v;
        axi_rd(TMR_CNT_BASE);
        chk(v, w);
        axi_wr(TMR_CONF_BASE, tcfg(0, 1, 1, 0, 18'h00100));
        axi_rd(TMR_CNT_BASE);
        chk(v, 0);
        axi_wr(TMR_CONF_BASE, tcfg(0, 1, 0, 0, 18'h00100));
        axi_wr(TMR_CONF_BASE + 12'h004, tcfg(0, 0, 0, 0, 18'h00100));
        span(1, 1, 0);
        chk(c, 400);
        axi_wr(GLOBAL_CONF_ADDR, 32'h1);
        axi_wr(TMR_CONF_BASE + 12'h010, tcfg(0, 1, 0, 0, 18'h00100));
        repeat (20) @(posedge ref_clk_in);
        axi_rd(TMR_CNT_BASE + 12'h010);
        chk(v, 0);
        axi_wr(TMR_CONF_BASE + 12'h010, tcfg(1, 1, 0, 0, 18'h00100));
        axi_wr(CH_BASE + 12'h080, 32'h1);
        axi_wr(CH_BASE + 12'h084, 32'h2);
        axi_wr(CH_BASE + 12'h088, 32'h30);
        span(4, 2, 8);
        chk(c, 16);
        chk(h, 6);
        axi_wr(GLOBAL_CONF_ADDR, 32'h0);
        axi_wr(TMR_CONF_BASE + 12'h010, tcfg(1, 1, 0, 0, 18'h00100));
        span(4, 1, 8);
        span(4, 1, 8);
        chk(c, 48);
        axi_wr(CH_BASE + 12'h010, 32'h1);
        axi_wr(CH_BASE + 12'h018, 32'h10);
        axi_wr(CH_BASE + 12'h01C, 32'hC0200401);
        fade_wait(1);
        axi_rd(DUTY_R_BASE + 12'h004);
        chk(v, 32'h30);
        // second fade only after done, step not 1 at the top
        axi_wr(CH_BASE + 12'h01C, 32'h80100402);
        fade_wait(1);
        axi_rd(DUTY_R_BASE + 12'h004);
        chk(v, 32'h10);
        close_out();
    end
    initial
    begin
        #400000;
        bad_count++;
        close_out();
    end
endmodule
bind pwm_fade_controller pwm_fade_monitor mon (.*);
